//--- shared/uart_autobaud_regs.svh
// Register map, field positions, reset values and timing counts for autobaud/wake
// Functional notes
// - Autobaud enable starts calibration, receiver held idle
// - Count starts on first rise after start
// - Time 55h sync, end on fifth rise
// - Leave divisor, clear enable, set receive flag
// - Divisor pair always one 16-bit counter
// - Counter runs at base clock over the rate-select divide
// - Rate select: /512, /128, /128, /32
// - Counter starts at one; software subtracts one
// - With wake set, measure character after break
// - Overflow flag set when count passes 16 bits
// - After overflow keep counting until fifth rise
// - Overflow stays set while enable still set
// - Wake enable holds receiver idle, watching line
// - Falling edge is wake event, sets flag
// - Rising edge ends break, clears wake enable
// - Non-zero character: first low time wakes
// - Sleep stops rate generator; only wake active
`ifndef UART_AUTOBAUD_REGS_SVH
`define UART_AUTOBAUD_REGS_SVH

// Register byte offsets
`define OFF_CTRL     8'h00
`define OFF_DIV      8'h04
`define OFF_STAT     8'h08
`define OFF_RXD      8'h0C

// Control register fields
`define CTRL_ABE     0
`define CTRL_WUE     1
`define CTRL_WIDE    2
`define CTRL_HS      3
`define CTRL_OVF     4

// Status register fields
`define STAT_RXF     0
`define STAT_IDLE    1

// Divisor field
`define DIV_MSB      15
`define DIV_START    16'h0001
`define DIV_ONES     16'hFFFF

// Prescale terminal counts for the autobaud clock
`define PRE_SLOW     9'h1FF
`define PRE_MID      9'h07F
`define PRE_FAST     9'h01F

// Edge bookkeeping
`define EDGE_FIRST   3'h1
`define EDGE_LAST    3'h4

// Idle level of the serial line and the all-zero bus word
`define LINE_IDLE    1'b1
`define WORD_ZERO    32'h0000_0000

`endif

//--- shared/uart_autobaud_pkg.sv
// Types shared by the autobaud and wake-on-break logic
package uart_autobaud_pkg;

    // Calibration and wake sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE     = 6'b00_0001,
        ST_WK_WATCH = 6'b00_0010,
        ST_WK_LOW   = 6'b00_0100,
        ST_AB_START = 6'b00_1000,
        ST_AB_FIRST = 6'b01_0000,
        ST_AB_MEAS  = 6'b10_0000
    } seq_state_t;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    // Whole state of the block
    typedef struct packed {
        seq_state_t  st;
        logic        abe;
        logic        wake_on_break_enable;
        logic        wide;
        logic        hs;
        logic        ovf;
        logic        rxf;
        logic        hold;
        logic [15:0] div;
        logic [8:0]  pre;
        logic [2:0]  edges;
        apb_rsp_t    rsp;
    } core_t;

    // Reset image of the state
    localparam core_t CORE_RST = '{st: ST_IDLE, default: '0};

endpackage : uart_autobaud_pkg

//--- rtl/line_edge_sync.sv
// Serial line synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
`include "uart_autobaud_regs.svh"
module line_edge_sync #(
    parameter int SYNC_STAGES = 2   // Flops before the edge detector
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    // Line in
    input  wire logic line_in,
    // Synchronised level and edges
    output logic      line_s,
    output logic      rise,
    output logic      fall
);

    // Refuse a chain too short to settle metastability
    if (SYNC_STAGES < 2) begin : g_bad_stages
        $error("line_edge_sync: SYNC_STAGES must be at least 2");
    end

    logic [SYNC_STAGES:0] sh_r;    // Chain plus one history flop
    logic [SYNC_STAGES:0] sh_nxt;  // Next chain value

    // Shift the line in; stage 0 feeds only stage 1
    always_comb begin
        sh_nxt = {sh_r[SYNC_STAGES-1:0], line_in};
    end

    // Idle high at reset so no false start is seen
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sh_r <= {(SYNC_STAGES+1){`LINE_IDLE}};
        end else if (clk_en) begin
            sh_r <= sh_nxt;
        end
    end

    // Edges from settled stages only
    assign line_s = sh_r[SYNC_STAGES-1];
    assign rise   = sh_r[SYNC_STAGES-1] & ~sh_r[SYNC_STAGES];
    assign fall   = ~sh_r[SYNC_STAGES-1] & sh_r[SYNC_STAGES];

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // Rise pulse matches a low-to-high step of the pin, chain delay behind
    chk_rise_settled: assert property (rise && $past(clk_en) && $past(clk_en, 2)
        && $past(clk_en, 3) |-> $past(line_in, SYNC_STAGES)
        && !$past(line_in, SYNC_STAGES + 1))
        else $error("rise pulse without settled edge");

endmodule : line_edge_sync

//--- rtl/uart_autobaud_wake.sv
// Autobaud measurement and wake-on-break logic with APB registers
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "uart_autobaud_regs.svh"
module uart_autobaud_wake
    import uart_autobaud_pkg::*;
(
    // Clock, reset and enable
    input  wire logic     sys_clk,
    input  wire logic     sys_rst,
    input  wire logic     clk_en,
    // APB slave
    input  wire apb_req_t apb_req,
    output apb_rsp_t      apb_rsp,
    // Serial line and power state
    input  wire logic     serial_input_line,
    input  wire logic     sleep_mode,
    // To the receive path
    output logic          receive_flag,
    output logic          rx_hold_idle
);

    core_t      r;        // Registered state
    core_t      n;        // Next state
    logic       line_s;   // Synchronised line level
    logic       rise;     // Line rose
    logic       fall;     // Line fell
    logic       tick;     // Autobaud clock tick
    logic [8:0] pre_lim;  // Prescale terminal count
    logic       carry;    // Divisor overflow carry
    logic       acc;      // APB transfer completes this edge
    logic       wr;       // Completing write
    logic       rd;       // Completing read
    logic       awake;    // Rate generator running

    // Line synchroniser and edge detector
    line_edge_sync #(
        .SYNC_STAGES (2)
    ) u_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .line_in (serial_input_line),
        .line_s  (line_s),
        .rise    (rise),
        .fall    (fall)
    );

    // Transfer qualifiers
    assign acc   = apb_req.psel & apb_req.penable & r.rsp.pready;
    assign wr    = acc & apb_req.pwrite;
    assign rd    = acc & ~apb_req.pwrite;
    assign awake = ~sleep_mode;

    // Autobaud clock select from the rate bits
    always_comb begin
        unique case ({r.wide, r.hs})
            2'b00:   pre_lim = `PRE_SLOW;
            2'b11:   pre_lim = `PRE_FAST;
            default: pre_lim = `PRE_MID;
        endcase
    end

    // Tick once per pre_lim plus one base periods; sleep stops it
    assign tick = awake && (r.st == ST_AB_MEAS) && (r.pre == pre_lim);

    // Next-state logic for registers, sequencer and bus
    always_comb begin
        n     = r;
        carry = 1'b0;

        // Software writes
        if (wr) begin
            case (apb_req.paddr)
                `OFF_CTRL: begin
                    n.abe  = apb_req.pwdata[`CTRL_ABE];
                    n.wake_on_break_enable  = apb_req.pwdata[`CTRL_WUE];
                    n.wide = apb_req.pwdata[`CTRL_WIDE];
                    n.hs   = apb_req.pwdata[`CTRL_HS];
                    // Overflow clears only once enable was already low
                    if (!apb_req.pwdata[`CTRL_OVF] && !r.abe) begin
                        n.ovf = 1'b0;
                    end
                end
                `OFF_DIV: begin
                    n.div = apb_req.pwdata[`DIV_MSB:0];
                end
                default: begin
                    // Read-only or unmapped: no effect
                end
            endcase
        end

        // Reading the data register clears the receive flag
        if (rd && apb_req.paddr == `OFF_RXD) begin
            n.rxf = 1'b0;
        end

        // Prescaler runs only while measuring and awake
        if (r.st == ST_AB_MEAS && awake) begin
            n.pre = tick ? 9'h000 : r.pre + 9'h001;
        end

        // Sequencer; hardware events override software above
        unique case (r.st)
            ST_IDLE: begin
                // Wake first, so measurement falls on the next character
                if (r.wake_on_break_enable) begin
                    n.st = ST_WK_WATCH;
                end else if (r.abe) begin
                    n.st = ST_AB_START;
                end
            end
            ST_WK_WATCH: begin
                // Falling edge is the wake event; works asleep too
                if (!r.wake_on_break_enable) begin
                    n.st = ST_IDLE;
                end else if (fall) begin
                    n.rxf = 1'b1;
                    n.st  = ST_WK_LOW;
                end
            end
            ST_WK_LOW: begin
                // First rise ends the break, whatever the character
                if (!r.wake_on_break_enable) begin
                    n.st = ST_IDLE;
                end else if (rise) begin
                    n.wake_on_break_enable = 1'b0;
                    n.st  = ST_IDLE;
                end
            end
            ST_AB_START: begin
                // Wait for the start bit
                if (!r.abe) begin
                    n.st = ST_IDLE;
                end else if (awake && fall) begin
                    n.st = ST_AB_FIRST;
                end
            end
            ST_AB_FIRST: begin
                // First rise after start: counter loads one
                if (!r.abe) begin
                    n.st = ST_IDLE;
                end else if (awake && rise) begin
                    n.div   = `DIV_START;
                    n.pre   = 9'h000;
                    n.edges = `EDGE_FIRST;
                    n.st    = ST_AB_MEAS;
                end
            end
            ST_AB_MEAS: begin
                if (!r.abe) begin
                    n.st = ST_IDLE;
                end else if (awake) begin
                    // Full 16-bit count regardless of divisor width
                    if (tick) begin
                        {carry, n.div} = {1'b0, r.div} + 17'h0_0001;
                        if (carry) begin
                            n.ovf = 1'b1;
                        end
                    end
                    // Fifth rise closes the sync character
                    if (rise) begin
                        if (r.edges == `EDGE_LAST) begin
                            n.rxf = 1'b1;
                            n.abe = 1'b0;
                            n.st  = ST_IDLE;
                        end else begin
                            n.edges = r.edges + 3'h1;
                        end
                    end
                end
            end
        endcase

        // Receiver held idle while measuring, watching or asleep
        n.hold = n.abe | n.wake_on_break_enable | sleep_mode;

        // APB answer one cycle into the access phase
        n.rsp.pready  = 1'b0;
        n.rsp.pslverr = 1'b0;
        if (apb_req.psel && apb_req.penable && !r.rsp.pready) begin
            n.rsp.pready = 1'b1;
            n.rsp.prdata = `WORD_ZERO;
            case (apb_req.paddr)
                `OFF_CTRL: begin
                    n.rsp.prdata[`CTRL_ABE]  = r.abe;
                    n.rsp.prdata[`CTRL_WUE]  = r.wake_on_break_enable;
                    n.rsp.prdata[`CTRL_WIDE] = r.wide;
                    n.rsp.prdata[`CTRL_HS]   = r.hs;
                    n.rsp.prdata[`CTRL_OVF]  = r.ovf;
                end
                `OFF_DIV: begin
                    n.rsp.prdata[`DIV_MSB:0] = r.div;
                end
                `OFF_STAT: begin
                    n.rsp.prdata[`STAT_RXF]  = r.rxf;
                    n.rsp.prdata[`STAT_IDLE] = !(r.st inside {ST_WK_LOW, ST_AB_FIRST,
                                                              ST_AB_MEAS});
                end
                `OFF_RXD: begin
                    // No character path here; value is discarded
                end
                default: begin
                    n.rsp.pslverr = 1'b1;
                end
            endcase
        end
    end

    // State register; enable low freezes everything
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= CORE_RST;
        end else if (clk_en) begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign apb_rsp      = r.rsp;
    assign receive_flag = r.rxf;
    assign rx_hold_idle = r.hold;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    chk_hold_while_busy: assert property (r.abe |-> rx_hold_idle)
        else $error("receiver not held idle during calibration");

    chk_first_rise_load: assert property (clk_en && awake && r.abe && r.st == ST_AB_FIRST
        && rise |=> r.div == `DIV_START && r.st == ST_AB_MEAS)
        else $error("first rise did not load divisor with one");

    chk_fifth_rise_end: assert property (clk_en && awake && r.abe && r.st == ST_AB_MEAS
        && rise && r.edges == `EDGE_LAST |=> !r.abe && r.rxf && r.st == ST_IDLE)
        else $error("fifth rise did not finish calibration");

    chk_div_increment: assert property (clk_en && tick && r.abe
        |=> r.div == $past(r.div) + 16'h0001)
        else $error("divisor did not advance on tick");

    chk_tick_spacing: assert property (clk_en && tick && r.abe && !rise ##1 clk_en
        && awake && r.st == ST_AB_MEAS |-> !tick)
        else $error("autobaud ticks too close");

    chk_ovf_carry: assert property (clk_en && tick && r.abe && r.div == `DIV_ONES
        |=> r.ovf && r.div == 16'h0000)
        else $error("overflow flag not set on wrap");

    chk_ovf_sticky: assert property (r.ovf && r.abe |=> r.ovf)
        else $error("overflow cleared while enable set");

    chk_wake_event: assert property (clk_en && r.wake_on_break_enable && r.st == ST_WK_WATCH && fall
        |=> r.rxf ##1 (r.rxf || $past(rd)))
        else $error("wake event did not raise receive flag");

    chk_break_end: assert property (clk_en && r.wake_on_break_enable && r.st == ST_WK_LOW && rise
        |=> !r.wake_on_break_enable && r.st == ST_IDLE)
        else $error("break end did not clear wake enable");

    chk_wake_before_ab: assert property (clk_en && r.st == ST_IDLE && r.wake_on_break_enable && r.abe
        |=> r.st == ST_WK_WATCH)
        else $error("measurement started before break");

    chk_sleep_freeze: assert property (sleep_mode && r.st == ST_AB_MEAS
        |=> $stable(r.div))
        else $error("divisor counted in sleep");

    cov_calibrated: cover property (r.st == ST_AB_MEAS ##1 r.st == ST_IDLE && r.rxf);
    cov_overflow:   cover property ($rose(r.ovf));
    cov_wake:       cover property (r.st == ST_WK_LOW ##1 r.st == ST_IDLE);
    cov_wake_ab:    cover property (r.st == ST_WK_LOW ##[1:1000] r.st == ST_AB_MEAS);

endmodule : uart_autobaud_wake

//--- testbench/serial_node.sv
// Remote serial node model that drives the receive line
`timescale 1ns/1ps
module serial_node (
    // Bit pacing clock
    input  wire logic clk,
    // Receive line of the block
    output logic      line
);
    // Line idles high outside frames
    initial line = 1'b1;

    // Hold one level for t clocks
    task automatic put_bit(input logic v, input int t);
        line <= v;
        repeat (t) @(posedge clk);
    endtask : put_bit

    // Start bit, eight bits LSB first, stop bit
    task automatic send_byte(input logic [7:0] b, input int t);
        @(posedge clk);
        put_bit(1'b0, t);
        for (int i = 0; i < 8; i++) begin
            put_bit(b[i], t);
        end
        put_bit(1'b1, t);
    endtask : send_byte

    // All-zero wake character, then back to idle
    task automatic send_break(input int nbits, input int t);
        @(posedge clk);
        put_bit(1'b0, nbits * t);
        put_bit(1'b1, t);
    endtask : send_break
endmodule : serial_node

//--- testbench/testbench.sv
// Self-checking bench for the autobaud and wake-on-break block
`timescale 1ns/1ps
`include "uart_autobaud_regs.svh"
`define check_eq(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
    import uart_autobaud_pkg::*;
    logic        sys_clk;     // 40 MHz clock
    logic        sys_rst;     // Async reset
    logic        clk_en;      // Clock enable, kept on
    logic        sleep_mode;  // Power state
    apb_req_t    req;         // APB request
    apb_rsp_t    rsp;         // APB answer
    logic        line;        // Receive line from the node
    logic        receive_flag;
    logic        rx_hold_idle;
    logic [31:0] rd_q;        // Last read data
    logic        rd_err;      // Last error response
    int          fails;
    int          cmp_count;

    // Block under test
    uart_autobaud_wake DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .apb_req(req), .apb_rsp(rsp), .serial_input_line(line), .sleep_mode(sleep_mode),
        .receive_flag(receive_flag), .rx_hold_idle(rx_hold_idle));

    // Far-side serial node
    serial_node node (.clk(sys_clk), .line(line));

    // Clock generator
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 40);
        `check_eq(rsp.pready, 1'b1);
        rd_q = rsp.prdata;
        rd_err = rsp.pslverr;
        req <= '0;
        #1;
    endtask : apb

    // Register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    // Register read and compare
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        `check_eq(rd_q, exp);
    endtask : chk_rd

    // Reset values, read-only and unmapped places
    task automatic t_reset;
        `check_eq(receive_flag, 1'b0);
        `check_eq(rx_hold_idle, 1'b0);
        chk_rd(`OFF_CTRL, 32'h0000_0000);
        chk_rd(`OFF_STAT, 32'h0000_0002);
        wr(`OFF_STAT, 32'h0000_0003);
        chk_rd(`OFF_STAT, 32'h0000_0002);
        wr(`OFF_DIV, 32'h1234_5678);
        chk_rd(`OFF_DIV, 32'h0000_5678);
        apb(1'b0, 8'h10, 32'h0000_0000);
        `check_eq(rd_q, 32'h0000_0000);
        `check_eq(rd_err, 1'b1);
        $display("t_reset done");
    endtask : t_reset

    // Calibration in every rate mode; half-tick offsets make counts exact
    task automatic t_autobaud;
        logic [31:0] sel [4] = '{32'h0000_0000, 32'h0000_0008, 32'h0000_0004, 32'h0000_000C};
        int          tb  [4] = '{160, 56, 56, 42};
        logic [31:0] dv  [4] = '{32'h0000_0003, 32'h0000_0004, 32'h0000_0004, 32'h0000_000B};
        for (int m = 0; m < 4; m++) begin
            wr(`OFF_CTRL, sel[m] | 32'h0000_0001);
            `check_eq(rx_hold_idle, 1'b1);
            node.send_byte(8'h55, tb[m]);
            `check_eq(receive_flag, 1'b1);
            chk_rd(`OFF_CTRL, sel[m]);
            chk_rd(`OFF_DIV, dv[m]);
            chk_rd(`OFF_STAT, 32'h0000_0003);
            chk_rd(`OFF_RXD, 32'h0000_0000);
            `check_eq(receive_flag, 1'b0);
            `check_eq(rx_hold_idle, 1'b0);
        end
        $display("t_autobaud done");
    endtask : t_autobaud

    // Break wakes, flag set while low, enable cleared at the end
    task automatic t_wake;
        chk_rd(`OFF_STAT, 32'h0000_0002);
        wr(`OFF_CTRL, 32'h0000_0002);
        `check_eq(rx_hold_idle, 1'b1);
        fork
            node.send_break(13, 42);
            begin
                repeat (30) @(posedge sys_clk);
                `check_eq(receive_flag, 1'b1);
                chk_rd(`OFF_CTRL, 32'h0000_0002);
                chk_rd(`OFF_STAT, 32'h0000_0001);
            end
        join
        chk_rd(`OFF_CTRL, 32'h0000_0000);
        `check_eq(rx_hold_idle, 1'b0);
        chk_rd(`OFF_RXD, 32'h0000_0000);
        `check_eq(receive_flag, 1'b0);
        $display("t_wake done");
    endtask : t_wake

    // Wake and calibration together: measure the byte after the break
    task automatic t_wake_cal;
        wr(`OFF_CTRL, 32'h0000_000F);
        node.send_break(13, 42);
        chk_rd(`OFF_CTRL, 32'h0000_000D);
        chk_rd(`OFF_RXD, 32'h0000_0000);
        `check_eq(receive_flag, 1'b0);
        node.send_byte(8'h55, 42);
        `check_eq(receive_flag, 1'b1);
        chk_rd(`OFF_DIV, 32'h0000_000B);
        chk_rd(`OFF_CTRL, 32'h0000_000C);
        chk_rd(`OFF_RXD, 32'h0000_0000);
        $display("t_wake_cal done");
    endtask : t_wake_cal

    // Overflow: preset count wraps, flag sticks while enabled, then cleared
    task automatic t_overflow;
        wr(`OFF_CTRL, 32'h0000_000D);
        fork
            node.send_byte(8'h55, 42);
            begin
                repeat (60) @(posedge sys_clk);
                wr(`OFF_DIV, 32'h0000_FFFF);
                repeat (20) @(posedge sys_clk);
                wr(`OFF_CTRL, 32'h0000_000D);
                chk_rd(`OFF_CTRL, 32'h0000_001D);
            end
        join
        `check_eq(receive_flag, 1'b1);
        chk_rd(`OFF_CTRL, 32'h0000_001C);
        chk_rd(`OFF_DIV, 32'h0000_0009);
        wr(`OFF_CTRL, 32'h0000_000C);
        chk_rd(`OFF_CTRL, 32'h0000_000C);
        chk_rd(`OFF_RXD, 32'h0000_0000);
        $display("t_overflow done");
    endtask : t_overflow

    // Non-zero byte: first low time counts as the wake event
    task automatic t_fragment;
        wr(`OFF_CTRL, 32'h0000_0002);
        node.send_byte(8'h10, 42);
        `check_eq(receive_flag, 1'b1);
        chk_rd(`OFF_CTRL, 32'h0000_0000);
        chk_rd(`OFF_RXD, 32'h0000_0000);
        $display("t_fragment done");
    endtask : t_fragment

    // Sleep: calibration frozen, abort by clearing enable, wake still works
    task automatic t_sleep;
        wr(`OFF_CTRL, 32'h0000_000D);
        @(posedge sys_clk);
        node.put_bit(1'b0, 42);
        node.put_bit(1'b1, 8);
        sleep_mode <= 1'b1;
        wr(`OFF_CTRL, 32'h0000_000D);
        `check_eq(rx_hold_idle, 1'b1);
        node.send_byte(8'h55, 42);
        `check_eq(receive_flag, 1'b0);
        chk_rd(`OFF_CTRL, 32'h0000_000D);
        chk_rd(`OFF_DIV, 32'h0000_0001);
        wr(`OFF_CTRL, 32'h0000_0002);
        node.send_break(13, 42);
        `check_eq(receive_flag, 1'b1);
        chk_rd(`OFF_CTRL, 32'h0000_0000);
        chk_rd(`OFF_RXD, 32'h0000_0000);
        @(posedge sys_clk);
        sleep_mode <= 1'b0;
        @(posedge sys_clk);
        #1;
        `check_eq(rx_hold_idle, 1'b0);
        $display("t_sleep done");
    endtask : t_sleep

    // Counts and verdict, then stop
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // Main sequence
    initial begin
        fails = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        sleep_mode = 1'b0;
        req = '0;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset;
        t_autobaud;
        t_wake;
        t_wake_cal;
        t_overflow;
        t_fragment;
        t_sleep;
        wrap_up;
    end

    // Watchdog, well above the expected run length
    initial begin
        repeat (40000) @(posedge sys_clk);
        fails++;
        wrap_up;
    end
endmodule : testbench
